//--- bench/tb.sv
// Self-checking bench for the timer mode and capture/compare control block
// Assumes the shared package and the trigger partner model are compiled first
`timescale 1ns/1ps
module tb;
	localparam logic [15:0] a_mode   = tmr_pkg::mode_reg_addr;
	localparam logic [15:0] a_ctrl   = tmr_pkg::capcmp_ctrl_addr;
	localparam logic [15:0] a_first  = tmr_pkg::capcmp_first_addr;
	localparam logic [15:0] a_second = tmr_pkg::capcmp_second_addr;
	localparam logic [15:0] a_count  = tmr_pkg::count_value_addr;
	logic        ref_clk;
	logic        rst;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [1:0]  first_edge_sel;
	logic [1:0]  second_edge_sel;
	logic        trig_in_first;
	logic        trig_in_second;
	logic        timer_out_pin;
	logic        irq_first_match;
	logic        irq_second_match;
	logic        rd_seen;
	logic        out_last;
	logic [15:0] expect_q[$];
	logic [15:0] rnd;
	int          fails;
	int          total_checks;
	int          n1;
	int          n2;
	int          nt;
	int          b1;
	int          b2;
	int          bt;
	int          seed;

	timer_mode_capture_compare_ctrl timer_mode_capture_compare_ctrl_i (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.first_edge_sel(first_edge_sel), .second_edge_sel(second_edge_sel),
		.trig_in_first(trig_in_first), .trig_in_second(trig_in_second),
		.timer_out_pin(timer_out_pin), .irq_first_match(irq_first_match),
		.irq_second_match(irq_second_match)
	);
	trig_partner trig_partner_i (
		.ref_clk(ref_clk), .trig_in_first(trig_in_first), .trig_in_second(trig_in_second)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check_val(input string what, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic check_cnt(input string what, input int e, input int g);
		total_checks++;
		if (g != e) begin
			fails++;
			$display("wrong value %s expected %0d seen %0d", what, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		expect_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Watches results: read data against the oldest note, counts pulses and toggles
	always @(posedge ref_clk) begin
		rd_seen <= reg_rd;
		out_last <= timer_out_pin;
		if (irq_first_match === 1'b1)
			n1 <= n1 + 1;
		if (irq_second_match === 1'b1)
			n2 <= n2 + 1;
		if (timer_out_pin !== out_last)
			nt <= nt + 1;
		if (rd_seen === 1'b1 && expect_q.size() > 0)
			check_val("read data", expect_q.pop_front(), reg_rdata);
	end

	initial begin
		repeat (100000) @(posedge ref_clk);
		fails++;
		close_out();
	end

	initial begin
		seed = 32'hf9013543;
		rst = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		first_edge_sel = 2'b01;
		second_edge_sel = 2'b11;
		rd_seen = 1'b0;
		out_last = 1'b0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(a_mode, {8'h00, tmr_pkg::reg_reset});
		rd(a_ctrl, {8'h00, tmr_pkg::reg_reset});
		rd(16'hff00, tmr_pkg::word_zero);
		$display("test reset done");
		wr(a_ctrl, 16'h0005);
		trig_partner_i.pulse(1'b0, 3);
		trig_partner_i.pulse(1'b1, 3);
		rd(a_count, tmr_pkg::word_zero);
		check_cnt("stopped requests", 0, n1 + n2);
		$display("test stopped done");
		rnd = 16'($unsigned($random(seed)) % 16);
		wr(a_mode, 16'h0004);
		repeat (rnd) @(posedge ref_clk);
		rd(a_count, rnd + tmr_pkg::word_one);
		b1 = n1;
		b2 = n2;
		trig_partner_i.pulse(1'b0, 3);
		trig_partner_i.pulse(1'b1, 3);
		repeat (4) @(posedge ref_clk);
		check_cnt("first captures", 2, n1 - b1);
		check_cnt("second captures", 1, n2 - b2);
		$display("test capture done");
		for (int i = 0; i < 2; i++) begin
			wr(a_mode, 16'h0000);
			first_edge_sel <= (i == 0) ? 2'b11 : 2'b00;
			wr(a_ctrl, 16'h0003);
			wr(a_first, 16'h1234);
			wr(a_mode, 16'h0004);
			b1 = n1;
			trig_partner_i.pulse(1'b0, 3);
			repeat (4) @(posedge ref_clk);
			check_cnt("reverse phase captures", i, n1 - b1);
			if (i == 0)
				rd(a_first, 16'h1234);
		end
		$display("test reverse phase done");
		wr(a_mode, 16'h0000);
		rnd = 16'($unsigned($random(seed)) % 32'hfff0) + 16'h0008;
		wr(a_ctrl, 16'h0000);
		wr(a_first, tmr_pkg::word_max);
		wr(a_second, rnd);
		rd(a_second, rnd);
		b1 = n1;
		b2 = n2;
		bt = nt;
		wr(a_mode, 16'h0004);
		repeat (65540) @(posedge ref_clk);
		check_cnt("first match", 1, n1 - b1);
		check_cnt("second match", 1, n2 - b2);
		check_cnt("output toggles", 2, nt - bt);
		rd(a_mode, 16'h0005);
		wr(a_mode, 16'h0004);
		rd(a_mode, 16'h0004);
		$display("test overflow done");
		wr(a_mode, 16'h0000);
		wr(a_first, 16'h0010);
		wr(a_mode, 16'h000c);
		repeat (39) @(posedge ref_clk);
		rd(a_count, 16'h0006);
		wr(a_mode, 16'h0000);
		rd(a_count, tmr_pkg::word_zero);
		first_edge_sel <= 2'b01;
		bt = nt;
		wr(a_mode, 16'h000a);
		trig_partner_i.pulse(1'b0, 3);
		rd(a_count, 16'h0004);
		check_cnt("edge mode toggles", 0, nt - bt);
		$display("test modes done");
		wr(a_mode, 16'h0000);
		wr(a_ctrl, 16'h0004);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(a_ctrl, {8'h00, tmr_pkg::reg_reset});
		rd(a_first, tmr_pkg::word_zero);
		$display("test second reset done");
		@(posedge ref_clk);
		close_out();
	end
endmodule

//--- bench/trig_partner.sv
// Model of the outside world driving the two trigger pins
// Assumes pins change just after a rising edge of ref_clk
`timescale 1ns/1ps
module trig_partner (
	// Clock
	input  wire logic ref_clk,
	// Trigger pins
	output logic      trig_in_first,
	output logic      trig_in_second
);
	initial begin
		trig_in_first = 1'b0;
		trig_in_second = 1'b0;
	end
	// High pulse then low rest, each held for len count clocks
	task automatic pulse(input logic which, input int len);
		@(posedge ref_clk);
		if (which)
			trig_in_second <= 1'b1;
		else
			trig_in_first <= 1'b1;
		repeat (len) @(posedge ref_clk);
		trig_in_first <= 1'b0;
		trig_in_second <= 1'b0;
		repeat (len) @(posedge ref_clk);
	endtask
endmodule

//--- rtl/timer_mode_capture_compare_ctrl.sv
// Mode, overflow and capture/compare control of a 16-bit timer
// Assumes ref_clk is the selected count clock and trigger pins are synchronous
// Functional notes
// - Counter runs whenever mode field is nonzero
// - Stopped: count zero, no toggles or requests
// - Modes free, clear on edge, clear on match
// - Output inverts on matches, optionally first edge, except in edge clear mode
// - Compare requests on match, capture on edges
// - Mode bit 0 is overflow flag, clearable
// - Overflow when first register FFFFH and wrap
// - Clear before count 0001H is overridden
// - Capture, then request one count later
// - Control bit 2: second register captures
// - Control bit 0: first register captures
// - Control bit 1 picks first capture trigger
// - Reverse phase with both edges: no capture
// - Reset clears both control registers
// - Edge field: 00 fall, 01 rise, 11 both
// - Edge accepted after two equal samples
`timescale 1ns/1ps
module timer_mode_capture_compare_ctrl (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Edge selects from the prescaler register
	input  wire logic [1:0]  first_edge_sel,
	input  wire logic [1:0]  second_edge_sel,
	// Trigger pins
	input  wire logic        trig_in_first,
	input  wire logic        trig_in_second,
	// Timer output and requests
	output logic             timer_out_pin,
	output logic             irq_first_match,
	output logic             irq_second_match
);
	trig_if trg ();
	assign trg.trig_in_first   = trig_in_first;
	assign trg.trig_in_second  = trig_in_second;
	assign trg.first_edge_sel  = tmr_pkg::edge_type'(first_edge_sel);
	assign trg.second_edge_sel = tmr_pkg::edge_type'(second_edge_sel);

	trig_filter u_filter (
		.ref_clk (ref_clk),
		.rst     (rst),
		.trg     (trg.filt)
	);

	logic [7:0]  timer_mode_reg;
	logic [7:0]  capcmp_ctrl_reg;
	logic [15:0] capcmp_first;
	logic [15:0] capcmp_second;
	logic [15:0] count_value;
	logic        wrap_seen;
	logic        cap_evt_first;
	logic        cap_evt_second;
	logic [7:0]  next_mode_reg;
	logic [7:0]  next_ctrl_reg;
	logic [15:0] next_first;
	logic [15:0] next_second;
	logic [15:0] next_count;
	logic        next_wrap_seen;
	logic        next_cap_first;
	logic        next_cap_second;
	logic        next_out;
	logic        next_irq_first;
	logic        next_irq_second;
	logic [15:0] next_rdata;

	tmr_pkg::mode_type mode;
	logic running;
	logic first_capture;
	logic second_capture;
	logic match_first;
	logic match_second;
	logic edge_first;
	logic edge_second;
	logic edge_inv;
	logic first_trig;
	logic overflow;

	assign mode = tmr_pkg::mode_type'({timer_mode_reg[tmr_pkg::mode_hi_bit],
		timer_mode_reg[tmr_pkg::mode_lo_bit]});
	assign running        = (mode != tmr_pkg::mode_stop);
	assign first_capture  = capcmp_ctrl_reg[tmr_pkg::first_cap_bit];
	assign second_capture = capcmp_ctrl_reg[tmr_pkg::second_cap_bit];
	assign edge_first     = running & trg.valid_first;
	assign edge_second    = running & trg.valid_second;
	assign edge_inv       = running & trg.inv_first;
	assign match_first    = running & ~first_capture & (count_value == capcmp_first);
	assign match_second   = running & ~second_capture & (count_value == capcmp_second);
	assign first_trig     = capcmp_ctrl_reg[tmr_pkg::first_trig_bit] ? edge_inv : edge_second;
	assign overflow       = running & (capcmp_first == tmr_pkg::word_max)
		& (count_value == tmr_pkg::word_max);

	// Counter, captures and control registers
	always_comb begin
		next_mode_reg   = timer_mode_reg;
		next_ctrl_reg   = capcmp_ctrl_reg;
		next_first      = capcmp_first;
		next_second     = capcmp_second;
		next_count      = count_value + tmr_pkg::word_one;
		next_wrap_seen  = overflow;
		next_cap_first  = 1'b0;
		next_cap_second = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				tmr_pkg::mode_reg_addr: begin
					next_mode_reg = {4'h0, reg_wdata[tmr_pkg::mode_hi_bit:0]};
				end
				tmr_pkg::capcmp_ctrl_addr: begin
					next_ctrl_reg = {5'h00, reg_wdata[tmr_pkg::second_cap_bit:0]};
				end
				tmr_pkg::capcmp_first_addr: begin
					next_first = reg_wdata;
				end
				tmr_pkg::capcmp_second_addr: begin
					next_second = reg_wdata;
				end
				default: begin
					next_first = capcmp_first;
				end
			endcase
		end
		// Set wins over a software clear, also while the wrap is pending
		if (overflow || (wrap_seen && count_value == tmr_pkg::word_zero)) begin
			next_mode_reg[tmr_pkg::ovf_bit] = 1'b1;
		end
		if (first_capture && first_trig) begin
			next_first     = count_value;
			next_cap_first = 1'b1;
		end
		if (second_capture && edge_first) begin
			next_second     = count_value;
			next_cap_second = 1'b1;
		end
		case (mode)
			tmr_pkg::mode_stop: begin
				next_count = tmr_pkg::word_zero;
			end
			tmr_pkg::mode_free: begin
				next_count = count_value + tmr_pkg::word_one;
			end
			tmr_pkg::mode_edge_clr: begin
				if (edge_first) begin
					next_count = tmr_pkg::word_zero;
				end
			end
			tmr_pkg::mode_match_clr: begin
				if (count_value == capcmp_first) begin
					next_count = tmr_pkg::word_zero;
				end
			end
			default: begin
				next_count = tmr_pkg::word_zero;
			end
		endcase
	end

	// Output inversion, requests and read data
	always_comb begin
		next_out = timer_out_pin;
		if (running && mode != tmr_pkg::mode_edge_clr) begin
			if (match_first || match_second ||
				(timer_mode_reg[tmr_pkg::out_timing_bit] && edge_first)) begin
				next_out = ~timer_out_pin;
			end
		end
		next_irq_first  = first_capture ? cap_evt_first : match_first;
		next_irq_second = second_capture ? cap_evt_second : match_second;
		next_rdata      = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				tmr_pkg::mode_reg_addr:      next_rdata = {8'h00, timer_mode_reg};
				tmr_pkg::capcmp_ctrl_addr:   next_rdata = {8'h00, capcmp_ctrl_reg};
				tmr_pkg::capcmp_first_addr:  next_rdata = capcmp_first;
				tmr_pkg::capcmp_second_addr: next_rdata = capcmp_second;
				tmr_pkg::count_value_addr:   next_rdata = count_value;
				default:                     next_rdata = tmr_pkg::word_zero;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer_mode_reg   <= tmr_pkg::reg_reset;
			capcmp_ctrl_reg  <= tmr_pkg::reg_reset;
			capcmp_first     <= tmr_pkg::word_zero;
			capcmp_second    <= tmr_pkg::word_zero;
			count_value      <= tmr_pkg::word_zero;
			wrap_seen        <= 1'b0;
			cap_evt_first    <= 1'b0;
			cap_evt_second   <= 1'b0;
			timer_out_pin    <= 1'b0;
			irq_first_match  <= 1'b0;
			irq_second_match <= 1'b0;
			reg_rdata        <= tmr_pkg::word_zero;
		end else begin
			timer_mode_reg   <= next_mode_reg;
			capcmp_ctrl_reg  <= next_ctrl_reg;
			capcmp_first     <= next_first;
			capcmp_second    <= next_second;
			count_value      <= next_count;
			wrap_seen        <= next_wrap_seen;
			cap_evt_first    <= next_cap_first;
			cap_evt_second   <= next_cap_second;
			timer_out_pin    <= next_out;
			irq_first_match  <= next_irq_first;
			irq_second_match <= next_irq_second;
			reg_rdata        <= next_rdata;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_stop_holds_zero: assert property (
		!running |=> count_value == tmr_pkg::word_zero)
		else $error("count not zero while stopped");
	chk_stop_no_irq: assert property (
		!running && !$past(running) |=> !irq_first_match && !irq_second_match)
		else $error("request while stopped");
	chk_free_increments: assert property (
		mode == tmr_pkg::mode_free && !reg_wr
		|=> count_value == $past(count_value) + tmr_pkg::word_one)
		else $error("free-running count did not advance");
	chk_match_clear_zero: assert property (
		mode == tmr_pkg::mode_match_clr && count_value == capcmp_first && !reg_wr
		|=> count_value == tmr_pkg::word_zero)
		else $error("match clear missed");
	chk_overflow_sets: assert property (
		overflow |=> timer_mode_reg[tmr_pkg::ovf_bit])
		else $error("overflow flag not set");
	chk_overflow_reset: assert property (
		overflow |=> ##1 timer_mode_reg[tmr_pkg::ovf_bit])
		else $error("overflow clear took effect too early");
	chk_match_irq: assert property (
		match_first |=> irq_first_match)
		else $error("compare request missing");
	chk_capture_irq_late: assert property (
		next_cap_second |=> !irq_second_match ##1 irq_second_match)
		else $error("capture request timing wrong");
	chk_edge_mode_out: assert property (
		mode == tmr_pkg::mode_edge_clr |=> timer_out_pin == $past(timer_out_pin))
		else $error("output inverted in edge clear mode");
	chk_inv_both_none: assert property (
		first_edge_sel == tmr_pkg::edge_both && capcmp_ctrl_reg[tmr_pkg::first_trig_bit]
		&& first_capture && !reg_wr |=> !cap_evt_first)
		else $error("reverse phase capture with both edges");

	cov_free_wrap: cover property (overflow ##1 count_value == tmr_pkg::word_zero);
	cov_edge_clear: cover property (mode == tmr_pkg::mode_edge_clr && edge_first);
	cov_first_capture: cover property (cap_evt_first ##1 irq_first_match);
	cov_out_toggle: cover property (running && $changed(timer_out_pin));
endmodule

//--- rtl/trig_filter.sv
// Noise filter and valid-edge detector for the two trigger pins
// Assumes pins are synchronous to ref_clk
`timescale 1ns/1ps
module trig_filter (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Trigger group
	trig_if.filt      trg
);
	logic [1:0] pin;
	logic [1:0] samp;
	logic [1:0] level;
	logic [1:0] next_samp;
	logic [1:0] next_level;
	logic [1:0] rise;
	logic [1:0] fall;
	tmr_pkg::edge_type sel [2];

	assign pin    = {trg.trig_in_second, trg.trig_in_first};
	assign sel[0] = trg.first_edge_sel;
	assign sel[1] = trg.second_edge_sel;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			// Level accepted only after two equal samples
			always_comb begin
				next_samp[i]  = pin[i];
				next_level[i] = level[i];
				if (pin[i] == samp[i] && pin[i] != level[i]) begin
					next_level[i] = pin[i];
				end
			end
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					samp[i]  <= 1'b0;
					level[i] <= 1'b0;
				end else begin
					samp[i]  <= next_samp[i];
					level[i] <= next_level[i];
				end
			end
			assign rise[i] = next_level[i] & ~level[i];
			assign fall[i] = ~next_level[i] & level[i];
		end
	endgenerate

	// Edge field decode
	function automatic logic valid_edge(tmr_pkg::edge_type s, logic r, logic f);
		case (s)
			tmr_pkg::edge_fall: valid_edge = f;
			tmr_pkg::edge_rise: valid_edge = r;
			tmr_pkg::edge_both: valid_edge = r | f;
			default:            valid_edge = 1'b0;
		endcase
	endfunction

	assign trg.valid_first  = valid_edge(sel[0], rise[0], fall[0]);
	assign trg.valid_second = valid_edge(sel[1], rise[1], fall[1]);
	// Reverse phase of the first pin; none when both edges chosen
	assign trg.inv_first = (sel[0] == tmr_pkg::edge_fall) ? rise[0] :
		(sel[0] == tmr_pkg::edge_rise) ? fall[0] : 1'b0;

	chk_filter_two_samples: assert property (@(posedge ref_clk) disable iff (rst)
		$changed(level[0]) |-> $past(pin[0], 2) == level[0])
		else $error("trigger level accepted on one sample");
endmodule

//--- shared/tmr_pkg.sv
// Constants shared by the timer mode and capture/compare control block
// Assumes a byte/halfword register port and one count clock
package tmr_pkg;
	localparam logic [15:0] mode_reg_addr    = 16'hff60;
	localparam logic [15:0] capcmp_ctrl_addr = 16'hff62;
	localparam logic [15:0] capcmp_first_addr  = 16'hff12;
	localparam logic [15:0] capcmp_second_addr = 16'hff14;
	localparam logic [15:0] count_value_addr   = 16'hff16;
	localparam logic [7:0]  reg_reset        = 8'h00;
	localparam logic [15:0] word_zero        = 16'h0000;
	localparam logic [15:0] word_one         = 16'h0001;
	localparam logic [15:0] word_max         = 16'hffff;
	localparam int ovf_bit        = 0;
	localparam int out_timing_bit = 1;
	localparam int mode_lo_bit    = 2;
	localparam int mode_hi_bit    = 3;
	localparam int first_cap_bit  = 0;
	localparam int first_trig_bit = 1;
	localparam int second_cap_bit = 2;
	typedef enum logic [1:0] {
		mode_stop      = 2'b00,
		mode_free      = 2'b01,
		mode_edge_clr  = 2'b10,
		mode_match_clr = 2'b11
	} mode_type;
	typedef enum logic [1:0] {
		edge_fall = 2'b00,
		edge_rise = 2'b01,
		edge_bad  = 2'b10,
		edge_both = 2'b11
	} edge_type;
endpackage

//--- shared/trig_if.sv
// Trigger pins, edge selects and filtered valid-edge pulses
// Assumes both ends share ref_clk
`timescale 1ns/1ps
interface trig_if;
	logic                 trig_in_first;
	logic                 trig_in_second;
	tmr_pkg::edge_type    first_edge_sel;
	tmr_pkg::edge_type    second_edge_sel;
	logic                 valid_first;
	logic                 valid_second;
	logic                 inv_first;
	modport filt (input trig_in_first, trig_in_second, first_edge_sel, second_edge_sel,
		output valid_first, valid_second, inv_first);
	modport core (output trig_in_first, trig_in_second, first_edge_sel, second_edge_sel,
		input valid_first, valid_second, inv_first);
endinterface
